/* pef_pkg.sv */
// Package with register map, field positions and counter limits of the PHY event flags block.
package pef_pkg;
  // Printed offsets are not multiples of four: they are register indices.
  localparam logic [7:0] IDX_PHY_CONTROL  = 8'h11;
  localparam logic [7:0] IDX_STATUS_ONE   = 8'h12;
  localparam logic [7:0] IDX_STATUS_TWO   = 8'h13;
  localparam logic [7:0] IDX_FALSE_CARRIER = 8'h14;
  localparam logic [7:0] IDX_RX_ERROR     = 8'h15;
  localparam int         ADDR_WIDTH       = 10;
  localparam logic [ADDR_WIDTH-1:0] ADDR_PHY_CONTROL   = {IDX_PHY_CONTROL, 2'b00};
  localparam logic [ADDR_WIDTH-1:0] ADDR_STATUS_ONE    = {IDX_STATUS_ONE, 2'b00};
  localparam logic [ADDR_WIDTH-1:0] ADDR_STATUS_TWO    = {IDX_STATUS_TWO, 2'b00};
  localparam logic [ADDR_WIDTH-1:0] ADDR_FALSE_CARRIER = {IDX_FALSE_CARRIER, 2'b00};
  localparam logic [ADDR_WIDTH-1:0] ADDR_RX_ERROR      = {IDX_RX_ERROR, 2'b00};
  // Control register bits.
  localparam int CTL_INT_OUT_SEL = 0;
  localparam int CTL_INT_EN      = 1;
  // Second status register: flags in 14:8, enables in 6:0.
  localparam int FLAG_LSB  = 8;
  localparam int EVT_COUNT = 7;
  localparam int JABBER    = 0;
  // First status register: half-full flags at 9:8, enables at 1:0.
  localparam int HALF_FLAG_LSB = 8;
  localparam logic [7:0]  FC_MAX  = 8'hff;
  localparam logic [7:0]  FC_HALF = 8'h7f;
  localparam logic [15:0] RE_MAX  = 16'hffff;
  localparam logic [15:0] RE_HALF = 16'h7fff;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage : pef_pkg

/* pef_event_flags.sv */
// Event flags, error counters and AXI4-Lite register slave of the PHY interrupt logic.
//
// Functional notes
// - Each event flag latches on its event; all but jabber clear when their register is read.
// - An event raises interrupt only if its own enable bit is set.
// - Interrupts also need global enable and pin-output select, control bits 1 and 0.
// - Flags latch even when their enable is clear; only the output is gated.
// - Autoneg error sets bit 14, enable bit 6, clear on read.
// - Page received sets bit 13, enable bit 5, clear on read.
// - Loopback FIFO overflow or underflow sets bit 12, enable bit 4, clear on read.
// - Crossover change sets bit 11, enable bit 3, clear on read.
// - Sleep event sets bit 10, enable bit 2, clear on read.
// - Polarity change sets bit 9, enable bit 1, clear on read.
// - Jabber sets bit 8, enable bit 0, not cleared by reads.
// - Bits 15 and 7 of second status register ignore writes and read zero.
// - False-carrier counter, 8 bits at 7:0, counts events, clears on read.
// - False-carrier counter saturates at FFh until read.
// - False-carrier count beyond 7Fh raises a half-full event.
// - Receive-error counter counts errors with carrier, data valid and invalid symbol.
// - Receive-error counter does not count in MII loopback.
// - Receive-error counter saturates at FFFFh.
// - Receive-error count beyond 7FFFh raises a half-full event.
// - Reading receive-error counter returns the count and clears it.
// - Pin select set makes shared pin an active-low interrupt, else power-down input.
// - Counter half-full events set clear-on-read flags 9 and 8 of first status register.
`timescale 1ns/10ps
`default_nettype none
module pef_event_flags (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        autonegErrorEvt,
  input  wire logic        pageReceivedEvt,
  input  wire logic        loopFifoFaultEvt,
  input  wire logic        crossoverChangeEvt,
  input  wire logic        sleepEvt,
  input  wire logic        polarityChangeEvt,
  input  wire logic        jabberEvt,
  input  wire logic        falseCarrierEvt,
  input  wire logic        rxErrorEvt,
  input  wire logic        carrierValid,
  input  wire logic        rxDataValid,
  input  wire logic        invalidSymbol,
  input  wire logic        miiLoopback,
  input  wire logic        irqPowerdownPinIn,
  output logic             irqPowerdownPinOut,
  output logic             irqPowerdownPinOe,
  output logic             powerDownReq
);

  // Pending flags, enables and counters.
  logic [6:0]  eventFlag_reg;
  logic [6:0]  eventEn_reg;
  logic [1:0]  halfFlag_reg;
  logic [1:0]  halfEn_reg;
  logic [1:0]  control_reg;
  logic [7:0]  fcCount_reg;
  logic [15:0] reCount_reg;
  logic        irqActive_reg;
  // Armed copies of the flags: only an event that found its enable set may drive the pin.
  logic [6:0]  eventArm_reg;
  logic [1:0]  halfArm_reg;

  // Bus state.
  logic        awHeld_reg;
  logic [9:0]  awAddr_reg;
  logic        wHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        bValid_reg;
  logic [1:0]  bResp_reg;
  logic        rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0]  rResp_reg;

  // Word-aligned address decode, reused by read and write paths.
  function automatic logic hit(input logic [9:0] addr, input logic [9:0] target);
    hit = (addr == target);
  endfunction : hit

  // Saturating increment used by both counters.
  function automatic logic [15:0] satInc(input logic [15:0] value, input logic [15:0] limit);
    satInc = (value == limit) ? value : value + 16'h0001;
  endfunction : satInc

  // Write path: address and data may arrive in either order.
  wire        wrFire   = awHeld_reg && wHeld_reg && !bValid_reg;
  wire        wrCtl    = wrFire && hit(awAddr_reg, pef_pkg::ADDR_PHY_CONTROL);
  wire        wrOne    = wrFire && hit(awAddr_reg, pef_pkg::ADDR_STATUS_ONE);
  wire        wrTwo    = wrFire && hit(awAddr_reg, pef_pkg::ADDR_STATUS_TWO);
  wire        wrMapped = hit(awAddr_reg, pef_pkg::ADDR_PHY_CONTROL) || hit(awAddr_reg, pef_pkg::ADDR_STATUS_ONE)
                      || hit(awAddr_reg, pef_pkg::ADDR_STATUS_TWO) || hit(awAddr_reg, pef_pkg::ADDR_FALSE_CARRIER)
                      || hit(awAddr_reg, pef_pkg::ADDR_RX_ERROR);

  // Read path: one read at a time, answered the cycle after acceptance.
  wire        rdFire   = s_axi_arvalid && !rValid_reg;
  wire        rdOne    = rdFire && hit(s_axi_araddr, pef_pkg::ADDR_STATUS_ONE);
  wire        rdTwo    = rdFire && hit(s_axi_araddr, pef_pkg::ADDR_STATUS_TWO);
  wire        rdFc     = rdFire && hit(s_axi_araddr, pef_pkg::ADDR_FALSE_CARRIER);
  wire        rdRe     = rdFire && hit(s_axi_araddr, pef_pkg::ADDR_RX_ERROR);
  wire        rdCtl    = rdFire && hit(s_axi_araddr, pef_pkg::ADDR_PHY_CONTROL);
  wire        rdMapped = rdOne || rdTwo || rdFc || rdRe || rdCtl;

  // Readback words; reserved bits tie to zero, so writes to them have no effect.
  wire [15:0] twoWord  = {1'b0, eventFlag_reg, 1'b0, eventEn_reg};
  wire [15:0] oneWord  = {6'h00, halfFlag_reg, 6'h00, halfEn_reg};
  wire [15:0] fcWord   = {8'h00, fcCount_reg};
  wire [15:0] ctlWord  = {14'h0000, control_reg};
  wire [15:0] rdWord   = rdTwo ? twoWord : rdOne ? oneWord : rdFc ? fcWord : rdRe ? reCount_reg :
                         rdCtl ? ctlWord : 16'h0000;

  // Event vector in flag order, bit 6 down to jabber at bit 0.
  wire [6:0]  eventIn  = {autonegErrorEvt, pageReceivedEvt, loopFifoFaultEvt, crossoverChangeEvt,
                          sleepEvt, polarityChangeEvt, jabberEvt};
  // Jabber flag is kept out of the clear-on-read mask.
  wire [6:0]  readClr  = rdTwo ? 7'h7e : 7'h00;
  // Set wins over the clear of the same cycle, so no event is lost to a read.
  wire [6:0]  eventFlagNext = (eventFlag_reg & ~readClr) | eventIn;

  // Counter events and half-full crossings.
  wire        reCountable = rxErrorEvt && carrierValid && rxDataValid && invalidSymbol && !miiLoopback;
  wire [7:0]  fcBase   = rdFc ? 8'h00 : fcCount_reg;
  wire [15:0] reBase   = rdRe ? 16'h0000 : reCount_reg;
  wire [15:0] fcInc    = satInc({8'h00, fcBase}, {8'h00, pef_pkg::FC_MAX});
  wire [7:0]  fcCountNext = falseCarrierEvt ? fcInc[7:0] : fcBase;
  wire [15:0] reCountNext = reCountable ? satInc(reBase, pef_pkg::RE_MAX) : reBase;
  wire        fcHalfEvt = falseCarrierEvt && (fcBase == pef_pkg::FC_HALF);
  wire        reHalfEvt = reCountable && (reBase == pef_pkg::RE_HALF);
  wire [1:0]  halfClr  = rdOne ? 2'b11 : 2'b00;
  wire [1:0]  halfFlagNext = (halfFlag_reg & ~halfClr) | {fcHalfEvt, reHalfEvt};

  // An enable written after its event leaves that event silent; a read disarms together with the flag.
  wire [6:0]  eventArmNext = (eventArm_reg & ~readClr) | (eventIn & eventEn_reg);
  wire [1:0]  halfArmNext  = (halfArm_reg & ~halfClr) | ({fcHalfEvt, reHalfEvt} & halfEn_reg);

  // Interrupt condition: any armed flag whose enable is still set, gated globally.
  wire        pendingEnabled = |(eventArm_reg & eventEn_reg) || |(halfArm_reg & halfEn_reg);
  wire        irqNext  = pendingEnabled && control_reg[pef_pkg::CTL_INT_EN]
                         && control_reg[pef_pkg::CTL_INT_OUT_SEL];

  // Control and enable registers, honouring the low byte strobe only.
  always_ff @(posedge clk) begin
    if (srst) begin
      control_reg <= 2'b00;
      eventEn_reg <= 7'h00;
      halfEn_reg  <= 2'b00;
    end else begin
      if (wrCtl && wStrb_reg[0]) begin
        control_reg <= wData_reg[1:0];
      end
      if (wrTwo && wStrb_reg[0]) begin
        eventEn_reg <= wData_reg[6:0];
      end
      if (wrOne && wStrb_reg[0]) begin
        halfEn_reg <= wData_reg[1:0];
      end
    end
  end

  // Flags, counters and the registered interrupt level.
  always_ff @(posedge clk) begin
    if (srst) begin
      eventFlag_reg <= 7'h00;
      halfFlag_reg  <= 2'b00;
      fcCount_reg   <= 8'h00;
      reCount_reg   <= 16'h0000;
      irqActive_reg <= 1'b0;
      eventArm_reg  <= 7'h00;
      halfArm_reg   <= 2'b00;
    end else begin
      eventFlag_reg <= eventFlagNext;
      halfFlag_reg  <= halfFlagNext;
      fcCount_reg   <= fcCountNext;
      reCount_reg   <= reCountNext;
      irqActive_reg <= irqNext;
      eventArm_reg  <= eventArmNext;
      halfArm_reg   <= halfArmNext;
    end
  end

  // Write channel holding registers; a channel is taken only while its slot is empty.
  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 10'h000;
      wHeld_reg  <= 1'b0;
      wData_reg  <= 32'h00000000;
      wStrb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  // Write response and read data; unmapped addresses answer SLVERR.
  always_ff @(posedge clk) begin
    if (srst) begin
      bValid_reg <= 1'b0;
      bResp_reg  <= pef_pkg::RESP_OKAY;
      rValid_reg <= 1'b0;
      rData_reg  <= 32'h00000000;
      rResp_reg  <= pef_pkg::RESP_OKAY;
    end else begin
      if (wrFire) begin
        bValid_reg <= 1'b1;
        bResp_reg  <= wrMapped ? pef_pkg::RESP_OKAY : pef_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValid_reg <= 1'b0;
      end
      if (rdFire) begin
        rValid_reg <= 1'b1;
        rData_reg  <= {16'h0000, rdWord};
        rResp_reg  <= rdMapped ? pef_pkg::RESP_OKAY : pef_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rValid_reg <= 1'b0;
      end
    end
  end

  // Handshake outputs are combinational from the slot state.
  assign s_axi_awready = !awHeld_reg;
  assign s_axi_wready  = !wHeld_reg;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;

  // Shared pin: driven low as an interrupt only when selected, otherwise sensed for power-down.
  // While selected as an interrupt output, the pin is driven high when idle so that no external pull-up is needed.
  assign irqPowerdownPinOe  = control_reg[pef_pkg::CTL_INT_OUT_SEL];
  assign irqPowerdownPinOut = !irqActive_reg;
  assign powerDownReq       = !control_reg[pef_pkg::CTL_INT_OUT_SEL] && !irqPowerdownPinIn;

  // Assertions guarding the flag, counter and pin behaviour.
  chk_flag_latch: assert property (@(posedge clk) disable iff (srst)
    autonegErrorEvt |=> eventFlag_reg[6]) else $error("Autoneg flag not latched.");
  chk_jabber_sticky: assert property (@(posedge clk) disable iff (srst)
    eventFlag_reg[0] |=> eventFlag_reg[0]) else $error("Jabber flag cleared.");
  chk_read_clears: assert property (@(posedge clk) disable iff (srst)
    (rdTwo && !pageReceivedEvt) |=> !eventFlag_reg[5]) else $error("Page flag survived read.");
  chk_fc_saturate: assert property (@(posedge clk) disable iff (srst)
    (fcCount_reg == 8'hff && !rdFc) |=> fcCount_reg == 8'hff) else $error("False carrier counter wrapped.");
  chk_re_loopback: assert property (@(posedge clk) disable iff (srst)
    (miiLoopback && !rdRe) |=> $stable(reCount_reg)) else $error("Error counter moved in loopback.");
  chk_re_half: assert property (@(posedge clk) disable iff (srst)
    ($past(reCount_reg) == 16'h7fff && reCount_reg == 16'h8000) |-> halfFlag_reg[0])
    else $error("Half-full flag missed.");
  chk_re_satur: assert property (@(posedge clk) disable iff (srst)
    (reCount_reg == 16'hffff && !rdRe) |=> reCount_reg == 16'hffff) else $error("Error counter wrapped.");
  chk_irq_gate: assert property (@(posedge clk) disable iff (srst)
    !control_reg[pef_pkg::CTL_INT_EN] |=> !irqActive_reg) else $error("Interrupt without global enable.");
  chk_irq_hold: assert property (@(posedge clk) disable iff (srst)
    (eventArm_reg[2] && eventEn_reg[2] && control_reg == 2'b11) |=> irqActive_reg)
    else $error("Interrupt dropped while pending.");
  // While the pin is selected as an interrupt output, an active interrupt level drives it low.
  chk_pin_mode: assert property (@(posedge clk) disable iff (srst)
    (irqActive_reg && control_reg[pef_pkg::CTL_INT_OUT_SEL]) |-> (irqPowerdownPinOe && !irqPowerdownPinOut))
    else $error("Pin not low on interrupt.");

  // A flag that arrived with its enable clear never becomes armed later.
  chk_arm_needs_en: assert property (@(posedge clk) disable iff (srst)
    ((eventArm_reg & ~$past(eventArm_reg) & ~$past(eventEn_reg)) == 7'h00))
    else $error("Event armed without its enable.");
  // The same holds for the counter half-full flags.
  chk_half_arm: assert property (@(posedge clk) disable iff (srst)
    ((halfArm_reg & ~$past(halfArm_reg) & ~$past(halfEn_reg)) == 2'b00))
    else $error("Half-full event armed without its enable.");

  // With nothing armed and enabled the pin releases on the next edge.
  chk_irq_quiet: assert property (@(posedge clk) disable iff (srst)
    ((eventArm_reg & eventEn_reg) == 7'h00 && (halfArm_reg & halfEn_reg) == 2'b00) |=> !irqActive_reg)
    else $error("Interrupt with nothing pending.");

  // Software writes land in the control and enable bits one edge after the commit.
  chk_ctl_write: assert property (@(posedge clk) disable iff (srst)
    (wrCtl && wStrb_reg[0]) |=> (control_reg == $past(wData_reg[1:0])))
    else $error("Control write lost.");
  chk_en_write: assert property (@(posedge clk) disable iff (srst)
    (wrTwo && wStrb_reg[0]) |=> (eventEn_reg == $past(wData_reg[6:0])))
    else $error("Enable write lost.");

  // Without a read no flag may drop, and every event shows up in its flag.
  chk_flags_hold: assert property (@(posedge clk) disable iff (srst)
    !rdTwo |=> ((~eventFlag_reg & $past(eventFlag_reg)) == 7'h00)) else $error("Flag dropped without read.");
  chk_event_sets: assert property (@(posedge clk) disable iff (srst)
    (|eventIn) |=> ((eventFlag_reg & $past(eventIn)) == $past(eventIn))) else $error("Event flag not set.");

  // A read leaves only the jabber flag and whatever fired during the read.
  chk_read_clears_all: assert property (@(posedge clk) disable iff (srst)
    rdTwo |=> (eventFlag_reg[6:1] == $past(eventIn[6:1]))) else $error("Flag survived its read.");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (srst)
    rdTwo |=> (s_axi_rdata[31:15] == 17'h00000 && !s_axi_rdata[7])) else $error("Reserved bit read as one.");

  // False-carrier counter: one per event below the ceiling, zero after a read.
  chk_fc_count: assert property (@(posedge clk) disable iff (srst)
    (falseCarrierEvt && !rdFc && fcCount_reg != pef_pkg::FC_MAX) |=> (fcCount_reg == $past(fcCount_reg) + 8'h01))
    else $error("False carrier count missed an event.");
  chk_fc_clear: assert property (@(posedge clk) disable iff (srst)
    (rdFc && !falseCarrierEvt) |=> (fcCount_reg == 8'h00)) else $error("False carrier count kept after read.");
  chk_fc_data: assert property (@(posedge clk) disable iff (srst)
    rdFc |=> (s_axi_rdata == {24'h000000, $past(fcCount_reg)})) else $error("False carrier readback wrong.");
  chk_fc_half: assert property (@(posedge clk) disable iff (srst)
    (falseCarrierEvt && !rdFc && fcCount_reg == pef_pkg::FC_HALF) |=> halfFlag_reg[1])
    else $error("False carrier half-full missed.");

  // Receive-error counter: only a fully qualified error outside loopback counts.
  chk_re_count: assert property (@(posedge clk) disable iff (srst)
    (rxErrorEvt && carrierValid && rxDataValid && invalidSymbol && !miiLoopback && !rdRe
     && reCount_reg != pef_pkg::RE_MAX) |=> (reCount_reg == $past(reCount_reg) + 16'h0001))
    else $error("Receive error not counted.");
  chk_re_half_set: assert property (@(posedge clk) disable iff (srst)
    (rxErrorEvt && carrierValid && rxDataValid && invalidSymbol && !miiLoopback && !rdRe
     && reCount_reg == pef_pkg::RE_HALF) |=> halfFlag_reg[0])
    else $error("Receive error half-full not raised.");
  chk_re_idle: assert property (@(posedge clk) disable iff (srst)
    (!invalidSymbol && !rdRe) |=> $stable(reCount_reg)) else $error("Receive error counted without bad symbol.");
  chk_re_clear: assert property (@(posedge clk) disable iff (srst)
    (rdRe && !rxErrorEvt) |=> (reCount_reg == 16'h0000)) else $error("Receive error count kept after read.");
  chk_re_data: assert property (@(posedge clk) disable iff (srst)
    rdRe |=> (s_axi_rdata == {16'h0000, $past(reCount_reg)})) else $error("Receive error readback wrong.");

  // Reading the first status register returns the half-full flags and then empties them.
  chk_one_data: assert property (@(posedge clk) disable iff (srst)
    rdOne |=> (s_axi_rdata == {22'h000000, $past(halfFlag_reg), 6'h00, $past(halfEn_reg)}))
    else $error("First status readback wrong.");
  chk_half_clear: assert property (@(posedge clk) disable iff (srst)
    (rdOne && !falseCarrierEvt && !rxErrorEvt) |=> (halfFlag_reg == 2'b00))
    else $error("Half-full flag kept after read.");

  // With the pin handed over as an input, the block never drives it and only senses power-down.
  chk_pin_input: assert property (@(posedge clk) disable iff (srst)
    !control_reg[pef_pkg::CTL_INT_OUT_SEL] |-> (!irqPowerdownPinOe && (powerDownReq == !irqPowerdownPinIn)))
    else $error("Pin driven while used as input.");

  // Answers stand unchanged until the master takes them.
  chk_b_stable: assert property (@(posedge clk) disable iff (srst)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("Write response withdrawn.");
  chk_r_stable: assert property (@(posedge clk) disable iff (srst)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("Read data withdrawn.");

  // Reset empties the flags and quiets both answers and the pin.
  chk_reset_quiet: assert property (@(posedge clk)
    srst |=> (!s_axi_bvalid && !s_axi_rvalid && !irqActive_reg && eventFlag_reg == 7'h00))
    else $error("State survived reset.");

endmodule : pef_event_flags
`default_nettype wire

/* tb_pef_event_flags.sv */
// Self-checking testbench of the PHY event flags, error counters and their register slave.
`timescale 1ns/10ps
`default_nettype none
module tb_pef_event_flags;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pinOut, pinOe, pdReq;
  logic [1:0]  bresp, rresp, rsp;
  logic [6:0]  evtBus = 7'h00, flags = 7'h00, en = 7'h00;
  logic [4:0]  rxIn = 5'h00, v;
  logic        fcEvt = 1'b0, pinIn = 1'b1, fcHalf = 1'b0, reHalf = 1'b0;
  logic [31:0] seed = 32'hebf3, r;
  int          errTotal = 0, nChecks = 0, cyc = 0, fcCnt = 0, reCnt = 0;

  pef_event_flags i_pef_event_flags (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .autonegErrorEvt(evtBus[6]), .pageReceivedEvt(evtBus[5]),
    .loopFifoFaultEvt(evtBus[4]), .crossoverChangeEvt(evtBus[3]), .sleepEvt(evtBus[2]),
    .polarityChangeEvt(evtBus[1]), .jabberEvt(evtBus[0]), .falseCarrierEvt(fcEvt), .rxErrorEvt(rxIn[4]),
    .carrierValid(rxIn[3]), .rxDataValid(rxIn[2]), .invalidSymbol(rxIn[1]), .miiLoopback(rxIn[0]),
    .irqPowerdownPinIn(pinIn), .irqPowerdownPinOut(pinOut), .irqPowerdownPinOe(pinOe), .powerDownReq(pdReq));

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  // Watchdog: the full run needs about 71000 cycles, so a hang is cut off well past that.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errTotal++;
      completeRun();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : completeRun

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Write master: address and data offered together, each dropped once taken, bready held until bvalid.
  task automatic axiWrite(input logic [9:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        rsp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axiWrite

  // Read master: the read data and response are taken at the edge where rvalid is sampled high.
  task automatic axiRead(input logic [9:0] a);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axiRead

  task automatic rdChk(input logic [9:0] a, input logic [31:0] exp);
    axiRead(a);
    check(rd, exp);
    check({30'h0, rsp}, {30'h0, pef_pkg::RESP_OKAY});
  endtask : rdChk

  // Pulses events for one cycle and lets the flag and the pin settle.
  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    evtBus <= e;
    @(posedge clk);
    evtBus <= 7'h00;
    flags = flags | e;
    repeat (3) @(posedge clk);
  endtask : pulse

  function automatic logic [31:0] st2();
    return {16'h0, 1'b0, flags, 1'b0, en};
  endfunction : st2

  // Main sequence; reads that clear update the model after the read returns.
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rdChk(pef_pkg::ADDR_STATUS_TWO, 32'h0);
    axiWrite(pef_pkg::ADDR_STATUS_TWO, 32'hffff);
    en = 7'h7f;
    rdChk(pef_pkg::ADDR_STATUS_TWO, st2());
    axiWrite(pef_pkg::ADDR_STATUS_TWO, 32'h0);
    en = 7'h00;
    axiWrite(pef_pkg::ADDR_PHY_CONTROL, 32'h3);
    rdChk(pef_pkg::ADDR_PHY_CONTROL, 32'h3);
    check({31'h0, pinOe}, 32'h1);
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i);
      check({31'h0, pinOut}, 32'h1);
      rdChk(pef_pkg::ADDR_STATUS_TWO, st2());
      flags = flags & 7'h01;
    end
    rdChk(pef_pkg::ADDR_STATUS_TWO, st2());
    // Each non-jabber enable alone: other events stay silent, its own event drives the pin until read.
    for (int i = 1; i < 7; i++) begin
      en = 7'h01 << i;
      axiWrite(pef_pkg::ADDR_STATUS_TWO, {25'h0, en});
      pulse(~en & 7'h7e);
      check({31'h0, pinOut}, 32'h1);
      rdChk(pef_pkg::ADDR_STATUS_TWO, st2());
      flags = flags & 7'h01;
      pulse(en);
      check({31'h0, pinOut}, 32'h0);
      if (i == 1) begin
        axiWrite(pef_pkg::ADDR_PHY_CONTROL, 32'h1);
        repeat (2) @(posedge clk);
        check({31'h0, pinOut}, 32'h1);
        axiWrite(pef_pkg::ADDR_PHY_CONTROL, 32'h3);
        repeat (2) @(posedge clk);
        check({31'h0, pinOut}, 32'h0);
      end
      rdChk(pef_pkg::ADDR_STATUS_TWO, st2());
      flags = flags & 7'h01;
      repeat (2) @(posedge clk);
      check({31'h0, pinOut}, 32'h1);
    end
    // An enable written after its event must not raise the pin for that old event.
    pulse(7'h02);
    en = 7'h42;
    axiWrite(pef_pkg::ADDR_STATUS_TWO, {25'h0, en});
    repeat (2) @(posedge clk);
    check({31'h0, pinOut}, 32'h1);
    rdChk(pef_pkg::ADDR_STATUS_TWO, st2());
    flags = flags & 7'h01;
    axiWrite(pef_pkg::ADDR_PHY_CONTROL, 32'h0);
    @(posedge clk);
    pinIn <= 1'b0;
    repeat (2) @(posedge clk);
    check({30'h0, pinOe, pdReq}, 32'h1);
    pinIn <= 1'b1;
    // Random counter traffic; each driven value lasts exactly one cycle.
    for (int k = 0; k < 400; k++) begin
      @(posedge clk);
      r = xs();
      v = {r[3:0] | r[7:4], r[8] & r[9]};
      rxIn <= v;
      fcEvt <= r[10];
      if (r[10] && fcCnt < 255) fcCnt++;
      if (fcCnt == 128 && r[10]) fcHalf = 1'b1;
      if (v == 5'b11110 && reCnt < 65535) reCnt++;
      if (reCnt == 32768 && v == 5'b11110) reHalf = 1'b1;
    end
    @(posedge clk);
    rxIn <= 5'h00;
    fcEvt <= 1'b0;
    rdChk(pef_pkg::ADDR_FALSE_CARRIER, fcCnt);
    rdChk(pef_pkg::ADDR_RX_ERROR, reCnt);
    rdChk(pef_pkg::ADDR_STATUS_ONE, {22'h0, fcHalf, reHalf, 8'h0});
    // Long run past both maxima; counters start from zero after the reads above.
    @(posedge clk);
    rxIn <= 5'b11110;
    fcEvt <= 1'b1;
    repeat (70000) @(posedge clk);
    rxIn <= 5'h00;
    fcEvt <= 1'b0;
    rdChk(pef_pkg::ADDR_STATUS_ONE, 32'h300);
    rdChk(pef_pkg::ADDR_FALSE_CARRIER, 32'hff);
    rdChk(pef_pkg::ADDR_RX_ERROR, 32'hffff);
    rdChk(pef_pkg::ADDR_FALSE_CARRIER, 32'h0);
    rdChk(pef_pkg::ADDR_RX_ERROR, 32'h0);
    // Unmapped place: error response, read data zero.
    axiRead(10'h3fc);
    check({rsp, rd[29:0]}, {pef_pkg::RESP_SLVERR, 30'h0});
    axiWrite(10'h3f0, 32'h1);
    check({30'h0, rsp}, {30'h0, pef_pkg::RESP_SLVERR});
    completeRun();
  end
endmodule : tb_pef_event_flags
`default_nettype wire
